/* File: design/dpdi_top.sv */
// Drive process-data interface: cyclic assemblies, configuration, acyclic access.
`default_nettype none

module dpdi_top #(
	parameter logic [15:0] FW_REV = 16'h0302   // Firmware revision seen by logic
) (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	// Connection state
	input  wire logic        conn_open_i,
	input  wire logic [7:0]  conn_out_inst_i,
	input  wire logic [7:0]  conn_in_inst_i,
	// Cyclic output assembly from the scanner
	input  wire logic        out_asm_valid_i,
	input  wire logic [127:0] out_asm_data_i,
	// Cyclic input assembly to the scanner
	output logic      [127:0] in_asm_data_o,
	// Configuration assembly, one parameter per strobe
	input  wire logic        cfg_wr_i,
	input  wire logic [7:0]  cfg_inst_i,
	input  wire logic [7:0]  cfg_par_i,
	input  wire logic [31:0] cfg_val_i,
	// Acyclic attribute access
	input  wire logic        acy_req_i,
	input  wire logic        acy_write_i,
	input  wire logic [7:0]  acy_class_i,
	input  wire logic [7:0]  acy_inst_i,
	input  wire logic [7:0]  acy_attr_i,
	input  wire logic [31:0] acy_wdata_i,
	output logic             acy_ack_o,
	output logic             acy_err_o,
	output logic      [31:0] acy_rdata_o,
	// Drive feedback
	input  wire logic        target_reached_i,
	input  wire logic        motor_power_i,
	input  wire logic        running_i,
	input  wire logic        error_i,
	input  wire logic [15:0] act_speed_i,
	input  wire logic [31:0] act_pos_i,
	// Motion commands
	output logic             jog_up_o,
	output logic             jog_down_o,
	output logic             release_o,
	output logic             direct_o,
	output logic             pos_start_o,
	output logic      [31:0] target_pos_o,
	output logic             err_ack_o,
	output logic             ref_set_o,
	output logic      [31:0] ref_val_o,
	output logic      [31:0] scale_num_o,
	output logic      [31:0] scale_den_o
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [15:0]            cw;        // Latest command word
		logic [31:0]            tgt;       // Accepted target, not stored
		logic                   tog_seen;  // Last command toggle seen
		logic                   sw_tog;    // Status toggle echo
		logic                   jog_up;
		logic                   jog_dn;
		logic                   pos_start; // One-cycle positioning start
		logic                   err_ack;   // One-cycle error acknowledge
		logic                   ref_set;   // One-cycle reference strobe
		logic [31:0]            ref_val;
		logic                   acy_ack;
		logic                   acy_err;
		logic [31:0]            acy_rdata;
		logic [15:0]            pk_last;   // Last request id seen
		dpdi_pkg::dpdi_pk_state_t pk_state;
		logic [15:0]            pk_req;    // Pending request id
		logic [31:0]            pk_val;    // Pending request value
		logic [15:0]            pk_rid;    // Reply id
		logic [31:0]            pk_rval;   // Reply value
		logic                   cfg_en;    // Enable seen for next value
		logic [7:0]             cfg_en_par;
		logic [127:0]           in_asm;    // Registered input assembly
	} dpdi_top_state_t;

	dpdi_top_state_t s_q;   // Registered state
	dpdi_top_state_t s_d;   // Next state

	// ****************************************************************
	// Field extraction
	// ****************************************************************
	logic [15:0] o_cw;      // Incoming command word
	logic [31:0] o_tgt;     // Incoming target
	logic [15:0] o_pk_id;   // Incoming channel request id
	logic [31:0] o_pk_val;  // Incoming channel value
	logic        cyc_on;    // Assembly connection is up
	logic [15:0] status_w;  // Live status word

	assign o_cw     = out_asm_data_i[dpdi_pkg::OA_CW +: 16];
	assign o_tgt    = out_asm_data_i[dpdi_pkg::OA_TGT +: 32];
	assign o_pk_id  = out_asm_data_i[dpdi_pkg::OA_PK_ID +: 16];
	assign o_pk_val = out_asm_data_i[dpdi_pkg::OA_PK_VAL +: 32];

	// Cyclic data counts only with both assembly instances agreed
	assign cyc_on = conn_open_i && conn_out_inst_i == dpdi_pkg::INST_OUT
		&& conn_in_inst_i == dpdi_pkg::INST_IN;

	// Status word built from live drive state
	always_comb begin
		status_w = 16'h0000;
		status_w[dpdi_pkg::SW_REACHED] = target_reached_i;
		status_w[dpdi_pkg::SW_TOGGLE]  = s_q.sw_tog;
		status_w[dpdi_pkg::SW_POWER]   = motor_power_i;
		status_w[dpdi_pkg::SW_RUNNING] = running_i;
		status_w[dpdi_pkg::SW_ERROR]   = error_i;
	end

	// ****************************************************************
	// Access arbitration and decode
	// ****************************************************************
	logic        acy_take;  // Acyclic request served now
	logic        pk_take;   // Channel request served now
	logic        acc_go;    // Some access served now
	logic        a_wr;      // Selected access is a write
	logic [7:0]  a_par;     // Selected parameter number
	logic [31:0] a_val;     // Selected write value
	logic        acc_ok;    // Access accepted
	logic        acc_st_we; // Access writes the store
	logic        acc_ref;   // Access references the position
	logic [31:0] acc_rd;    // Read result
	logic [31:0] st_rdata;  // Store read data
	logic        cfg_ok;    // Configuration strobe for our instance
	logic        cfg_val;   // Strobe carries an enabled value
	logic        st_we;     // Store write
	logic [6:0]  st_waddr;
	logic [31:0] st_wdata;

	// Configuration wins; acyclic waits while any strobe to our instance is present, channel also waits for acyclic
	assign cfg_ok  = cfg_wr_i && cfg_inst_i == dpdi_pkg::INST_CFG;
	assign cfg_val = cfg_ok && !cfg_par_i[0] && cfg_par_i > dpdi_pkg::CFG_EN_LO
		&& cfg_par_i <= dpdi_pkg::CFG_VAL_HI && s_q.cfg_en
		&& s_q.cfg_en_par == 8'(cfg_par_i - 8'h01);
	assign acy_take = acy_req_i && !s_q.acy_ack && !cfg_ok;
	assign pk_take  = s_q.pk_state == dpdi_pkg::PK_PEND && !acy_take && !cfg_ok;
	assign acc_go   = acy_take || pk_take;
	// Attribute and channel number select the same entry
	assign a_par = acy_take ? acy_attr_i : s_q.pk_req[7:0];
	assign a_wr  = acy_take ? acy_write_i
		: s_q.pk_req[15:12] == dpdi_pkg::PK_WRITE;
	assign a_val = acy_take ? acy_wdata_i : s_q.pk_val;

	// Decode one access against the live and stored parameters
	always_comb begin
		acc_ok    = 1'b1;
		acc_st_we = 1'b0;
		acc_ref   = 1'b0;
		acc_rd    = 32'h0000_0000;
		if (acy_take && (acy_class_i != dpdi_pkg::CIP_CLASS
			|| acy_inst_i != dpdi_pkg::CIP_INST)) begin
			acc_ok = 1'b0;
		end else if (!acy_take && s_q.pk_req[15:12] != dpdi_pkg::PK_READ
			&& !a_wr) begin
			acc_ok = 1'b0;   // Unknown channel op
		end else begin
			case (a_par)
				// Command and target are writable only as cyclic fields
				dpdi_pkg::PAR_CTRL: begin
					acc_rd = {16'h0000, s_q.cw};
					acc_ok = !a_wr;
				end
				dpdi_pkg::PAR_TGT: begin
					acc_rd = s_q.tgt;
					acc_ok = !a_wr;
				end
				dpdi_pkg::PAR_STATUS: begin
					acc_rd = {16'h0000, status_w};
					acc_ok = !a_wr;
				end
				dpdi_pkg::PAR_SPEED: begin
					acc_rd = {{16{act_speed_i[15]}}, act_speed_i};
					acc_ok = !a_wr;
				end
				// Referencing a moving axle is refused
				dpdi_pkg::PAR_ACTPOS: begin
					acc_rd  = act_pos_i;
					acc_ok  = !a_wr || !running_i;
					acc_ref = a_wr && !running_i;
				end
				default: begin
					acc_rd    = st_rdata;
					acc_ok    = !a_par[7];
					acc_st_we = a_wr && !a_par[7];
				end
			endcase
		end
	end

	assign st_we    = cfg_val || (acc_go && acc_st_we);
	assign st_waddr = cfg_val ? cfg_par_i[6:0] : a_par[6:0];
	assign st_wdata = cfg_val ? cfg_val_i : a_val;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		s_d = s_q;
		s_d.pos_start = 1'b0;
		s_d.err_ack   = 1'b0;
		s_d.ref_set   = 1'b0;
		s_d.acy_ack   = 1'b0;
		// Dropped connection clears the command so motion stops
		if (!cyc_on) begin
			s_d.cw = 16'h0000;
		end else if (out_asm_valid_i) begin
			s_d.cw = o_cw;
			// A changed toggle marks a new command
			if (o_cw[dpdi_pkg::CW_TOGGLE] != s_q.tog_seen) begin
				s_d.tog_seen = o_cw[dpdi_pkg::CW_TOGGLE];
				s_d.sw_tog   = o_cw[dpdi_pkg::CW_TOGGLE];
				if (o_cw[dpdi_pkg::CW_XFER]) begin
					s_d.tgt       = o_tgt;
					s_d.pos_start = o_cw[dpdi_pkg::CW_RELEASE];
				end
			end
			// Acknowledge on the rising edge of the bit only
			if (o_cw[dpdi_pkg::CW_ERR_ACK] && !s_q.cw[dpdi_pkg::CW_ERR_ACK]
				&& FW_REV >= dpdi_pkg::FW_ACK_MIN) begin
				s_d.err_ack = 1'b1;
			end
			// A new request id starts one channel job, unless its op is none, which clears the reply
			if (o_pk_id != s_q.pk_last) begin
				s_d.pk_last = o_pk_id;
				if (o_pk_id[15:12] != dpdi_pkg::PK_NONE) begin
					s_d.pk_state = dpdi_pkg::PK_PEND;
					s_d.pk_req   = o_pk_id;
					s_d.pk_val   = o_pk_val;
				end else begin
					s_d.pk_rid  = 16'h0000;
					s_d.pk_rval = 32'h0000_0000;
				end
			end
		end
		// Manual runs need the release and a single direction
		s_d.jog_up = s_d.cw[dpdi_pkg::CW_RELEASE] && s_d.cw[dpdi_pkg::CW_JOG_UP]
			&& !s_d.cw[dpdi_pkg::CW_JOG_DN];
		s_d.jog_dn = s_d.cw[dpdi_pkg::CW_RELEASE] && s_d.cw[dpdi_pkg::CW_JOG_DN]
			&& !s_d.cw[dpdi_pkg::CW_JOG_UP];
		// Configuration enable is remembered for the following value
		if (cfg_ok) begin
			if (cfg_par_i[0] && cfg_par_i >= dpdi_pkg::CFG_EN_LO
				&& cfg_par_i < dpdi_pkg::CFG_VAL_HI) begin
				s_d.cfg_en     = cfg_val_i != 32'h0000_0000;
				s_d.cfg_en_par = cfg_par_i;
			end else begin
				s_d.cfg_en = 1'b0;
			end
		end
		// Access results
		if (acy_take) begin
			s_d.acy_ack   = 1'b1;
			s_d.acy_err   = !acc_ok;
			s_d.acy_rdata = acc_rd;
		end else if (pk_take) begin
			// A request captured in this very cycle must stay pending, or it is lost
			if ({s_d.pk_req, s_d.pk_val} == {s_q.pk_req, s_q.pk_val}) begin
				s_d.pk_state = dpdi_pkg::PK_IDLE;
			end
			s_d.pk_rid   = {acc_ok ? s_q.pk_req[15:12] : dpdi_pkg::PK_ERR,
				4'h0, s_q.pk_req[7:0]};
			s_d.pk_rval  = acc_rd;
		end
		if (acc_go && acc_ref) begin
			s_d.ref_set = 1'b1;
			s_d.ref_val = a_val;
		end
		// Input assembly refreshed every cycle
		s_d.in_asm = {s_q.pk_rval, s_q.pk_rid, 16'h0000, act_pos_i,
			act_speed_i, status_w};
	end

	// Target reset to its delivery value, never from the store
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_q     <= '0;
			s_q.tgt <= dpdi_pkg::TGT_DEF;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************************************
	// Store and outputs
	// ****************************************************************
	dpdi_par_store u_store (
		.sys_clk_i   (sys_clk_i),
		.sys_rst_i   (sys_rst_i),
		.we_i        (st_we),
		.waddr_i     (st_waddr),
		.wdata_i     (st_wdata),
		.raddr_i     (a_par[6:0]),
		.rdata_o     (st_rdata),
		.scale_num_o (scale_num_o),
		.scale_den_o (scale_den_o)
	);

	assign in_asm_data_o = s_q.in_asm;
	assign acy_ack_o     = s_q.acy_ack;
	assign acy_err_o     = s_q.acy_err;
	assign acy_rdata_o   = s_q.acy_rdata;
	assign jog_up_o      = s_q.jog_up;
	assign jog_down_o    = s_q.jog_dn;
	assign release_o     = s_q.cw[dpdi_pkg::CW_RELEASE];
	assign direct_o      = s_q.cw[dpdi_pkg::CW_DIRECT];
	assign pos_start_o   = s_q.pos_start;
	assign target_pos_o  = s_q.tgt;
	assign err_ack_o     = s_q.err_ack;
	assign ref_set_o     = s_q.ref_set;
	assign ref_val_o     = s_q.ref_val;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	a_jog_needs_release : assert property ((jog_up_o || jog_down_o) |-> release_o)
		else $error("manual run without release");
	a_start_takes_target : assert property (pos_start_o |->
		target_pos_o == $past(o_tgt) && release_o)
		else $error("start without the sent target");
	a_toggle_echo : assert property (cyc_on && out_asm_valid_i
		&& o_cw[dpdi_pkg::CW_TOGGLE] != s_q.tog_seen |-> ##2
		in_asm_data_o[dpdi_pkg::SW_TOGGLE] == $past(o_cw[dpdi_pkg::CW_TOGGLE], 2))
		else $error("status toggle did not echo");
	a_bad_class_err : assert property (acy_take && acy_class_i != dpdi_pkg::CIP_CLASS
		|=> acy_ack_o && acy_err_o)
		else $error("wrong class accepted");
	a_ref_standstill : assert property (ref_set_o |-> !$past(running_i))
		else $error("referenced while running");
	a_cfg_disabled : assert property (cfg_ok && !s_q.cfg_en |-> !cfg_val)
		else $error("disabled configuration value adopted");
	a_pos_feedback : assert property (##1 in_asm_data_o[dpdi_pkg::IA_POS +: 32]
		== $past(act_pos_i))
		else $error("position feedback stale");
	a_chan_reply : assert property (s_q.pk_state == dpdi_pkg::PK_PEND && !cfg_wr_i
		&& !acy_req_i |=> s_q.pk_rid[7:0] == $past(s_q.pk_req[7:0])
		##1 in_asm_data_o[dpdi_pkg::IA_PK_ID +: 8] == $past(s_q.pk_req[7:0], 2))
		else $error("channel reply missing");
	a_err_ack_edge : assert property (err_ack_o |-> $past(o_cw[dpdi_pkg::CW_ERR_ACK])
		&& !$past(s_q.cw[dpdi_pkg::CW_ERR_ACK]))
		else $error("error ack without rising bit");
endmodule : dpdi_top

`default_nettype wire

/* File: design/dpdi_pkg.sv */
// Constants and types shared by the drive process-data interface.
`default_nettype none

package dpdi_pkg;
	// ****************************************************************
	// Assembly layout
	// ****************************************************************
	localparam int ASM_W      = 128;              // 16 bytes
	localparam logic [7:0] INST_OUT = 8'h64;      // Output assembly 100
	localparam logic [7:0] INST_IN  = 8'h65;      // Input assembly 101
	localparam logic [7:0] INST_CFG = 8'h68;      // Configuration 104
	localparam int OA_CW      = 0;                // Command word lsb
	localparam int OA_TGT     = 16;               // Target position lsb
	localparam int OA_PK_ID   = 48;               // Channel request id lsb
	localparam int OA_PK_VAL  = 64;               // Channel request value lsb
	localparam int IA_SW      = 0;                // Status word lsb
	localparam int IA_SPD     = 16;               // Actual speed lsb
	localparam int IA_POS     = 32;               // Actual position lsb
	localparam int IA_PK_ID   = 80;               // Channel reply id lsb
	localparam int IA_PK_VAL  = 96;               // Channel reply value lsb

	// ****************************************************************
	// Command and status bit positions
	// ****************************************************************
	localparam int CW_JOG_UP  = 0;
	localparam int CW_JOG_DN  = 1;
	localparam int CW_XFER    = 2;
	localparam int CW_RELEASE = 4;
	localparam int CW_DIRECT  = 6;
	localparam int CW_TOGGLE  = 13;
	localparam int CW_ERR_ACK = 14;
	localparam int SW_REACHED = 0;
	localparam int SW_TOGGLE  = 2;
	localparam int SW_POWER   = 4;
	localparam int SW_RUNNING = 6;
	localparam int SW_ERROR   = 9;

	// ****************************************************************
	// Parameter channel codes (id word: op in 15:12, number in 7:0)
	// ****************************************************************
	localparam logic [3:0] PK_NONE  = 4'h0;
	localparam logic [3:0] PK_READ  = 4'h1;
	localparam logic [3:0] PK_WRITE = 4'h2;
	localparam logic [3:0] PK_ERR   = 4'h7;

	// ****************************************************************
	// Parameter numbers and addressing
	// ****************************************************************
	localparam logic [7:0] PAR_CTRL   = 8'h03;
	localparam logic [7:0] PAR_TGT    = 8'h04;
	localparam logic [7:0] PAR_STATUS = 8'h08;
	localparam logic [7:0] PAR_SPEED  = 8'h09;
	localparam logic [7:0] PAR_ACTPOS = 8'h0A;
	localparam logic [7:0] PAR_NUM    = 8'h1C;    // Scale numerator, 28
	localparam logic [7:0] PAR_DEN    = 8'h1E;    // Scale denominator, 30
	localparam logic [7:0] CFG_EN_LO  = 8'h19;    // First enable, 25
	localparam logic [7:0] CFG_VAL_HI = 8'h6E;    // Last value, 110
	localparam int PAR_N              = 128;      // Store depth
	localparam logic [7:0] CIP_CLASS  = 8'h64;
	localparam logic [7:0] CIP_INST   = 8'h01;
	localparam logic [15:0] FW_ACK_MIN = 16'h0302; // Error ack from V3.02

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [31:0] PAR_DEF   = 32'h0000_0000;
	localparam logic [31:0] SCALE_DEF = 32'h0000_0001;
	localparam logic [31:0] TGT_DEF   = 32'h0000_0000;

	typedef enum logic {PK_IDLE, PK_PEND} dpdi_pk_state_t;
endpackage : dpdi_pkg

`default_nettype wire

/* File: design/dpdi_par_store.sv */
// Parameter store: one word per parameter number, delivery defaults on reset.
`default_nettype none

module dpdi_par_store (
	// Clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	// Write port
	input  wire logic        we_i,
	input  wire logic [6:0]  waddr_i,
	input  wire logic [31:0] wdata_i,
	// Read port
	input  wire logic [6:0]  raddr_i,
	output logic      [31:0] rdata_o,
	// Scaling for the position unit
	output logic      [31:0] scale_num_o,
	output logic      [31:0] scale_den_o
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [dpdi_pkg::PAR_N-1:0][31:0] mem;   // Stored values
	} dpdi_store_t;

	dpdi_store_t s_q;   // Registered store
	dpdi_store_t s_d;   // Next store

	// Single write port; callers arbitrate before reaching here
	always_comb begin
		s_d = s_q;
		if (we_i) begin
			s_d.mem[waddr_i] = wdata_i;
		end
	end

	// Delivery defaults; backing up to external memory is outside this block
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
			s_q.mem[dpdi_pkg::PAR_NUM[6:0]] <= dpdi_pkg::SCALE_DEF;
			s_q.mem[dpdi_pkg::PAR_DEN[6:0]] <= dpdi_pkg::SCALE_DEF;
		end else begin
			s_q <= s_d;
		end
	end

	// Read is a plain index into the flops
	assign rdata_o     = s_q.mem[raddr_i];
	assign scale_num_o = s_q.mem[dpdi_pkg::PAR_NUM[6:0]];
	assign scale_den_o = s_q.mem[dpdi_pkg::PAR_DEN[6:0]];

	// Default is in place right after reset
	a_scale_default : assert property (@(posedge sys_clk_i)
		$fell(sys_rst_i) |-> scale_num_o == dpdi_pkg::SCALE_DEF)
		else $error("scale numerator not at delivery value");
endmodule : dpdi_par_store

`default_nettype wire

/* File: bench/dpdi_scanner_model.sv */
// Scanner model: cyclic frames, configuration strobes and attribute requests.
`default_nettype none

module dpdi_scanner_model (
	// Clock
	input  wire logic         sys_clk_i,
	// Cyclic frames
	output logic              out_valid_o,
	output logic [127:0]      out_data_o,
	// Configuration strobes: instance, parameter, value
	output logic              cfg_wr_o,
	output logic [47:0]       cfg_o,
	// Attribute requests: class, instance, attribute
	output logic              acy_req_o,
	output logic              acy_write_o,
	output logic [23:0]       acy_addr_o,
	output logic [31:0]       acy_wdata_o,
	input  wire logic         acy_ack_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Idle levels and request tasks
	// ****************************************************************
	initial begin
		out_valid_o = 1'b0;
		out_data_o  = 128'h0;
		cfg_wr_o    = 1'b0;
		cfg_o       = 48'h0;
		acy_req_o   = 1'b0;
		acy_write_o = 1'b0;
		acy_addr_o  = 24'h0;
		acy_wdata_o = 32'h0;
	end

	// One frame per high cycle; old content is scrambled so nothing stale is reused
	task automatic frame(input logic [15:0] cw, input logic [31:0] tgt, input logic [47:0] pk);
		@(negedge sys_clk_i);
		out_valid_o = 1'b1;
		out_data_o  = {32'h0, pk, tgt, cw};
		@(negedge sys_clk_i);
		out_valid_o = 1'b0;
		out_data_o  = ~out_data_o;
	endtask : frame

	// One configuration entry per strobe
	task automatic cfg(input logic [47:0] c);
		@(negedge sys_clk_i);
		cfg_wr_o = 1'b1;
		cfg_o    = c;
		@(negedge sys_clk_i);
		cfg_wr_o = 1'b0;
		cfg_o    = ~c;
	endtask : cfg

	// Request held until acknowledge or for at most 8 cycles, then dropped and data scrambled
	task automatic acy(input logic wr, input logic [23:0] a, input logic [31:0] d);
		@(negedge sys_clk_i);
		acy_req_o   = 1'b1;
		acy_write_o = wr;
		acy_addr_o  = a;
		acy_wdata_o = d;
		for (int i = 0; i < 8 && !acy_ack_i; i++) begin
			@(negedge sys_clk_i);
		end
		acy_req_o   = 1'b0;
		acy_wdata_o = ~d;
	endtask : acy
endmodule : dpdi_scanner_model

`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the drive process-data interface.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Signals, expectation queues and counters
	// ****************************************************************
	logic         clk = 1'b0;     // 200 MHz
	logic         rst = 1'b1;     // Active-high reset
	logic         conn = 1'b0;    // Assembly connection open
	logic [3:0]   fb = 4'h0;      // Error, running, power, reached
	logic [15:0]  spd = 16'h0;
	logic [31:0]  pos = 32'h0;
	logic [15:0]  inst = 16'h6465; // Output and input assembly instances
	logic         ov, cwr, ar, aw, ack, aerr, jup, jdn, rel, dir, pst, eack, rset;
	logic [127:0] od, ia;
	logic [47:0]  cfg;
	logic [23:0]  aa;
	logic [31:0]  ad, ard, tpos, rval, snum, sden, r, t;
	logic [33:0]  e;              // {data checked, error, data}
	logic [33:0]  acy_q[$];
	logic [31:0]  pos_q[$];
	logic [31:0]  ref_q[$];
	int           mismatches = 0;
	int           cmp_count = 0;
	int           acks = 0;
	logic [15:0]  jcw [4] = '{16'h2011, 16'h2001, 16'h2012, 16'h2050};
	logic [3:0]   jex [4] = '{4'b1001, 4'b0000, 4'b0101, 4'b0011};

	always #2.5 clk = ~clk;

	dpdi_scanner_model dpdi_scanner_model_inst (.sys_clk_i(clk), .out_valid_o(ov),
		.out_data_o(od), .cfg_wr_o(cwr), .cfg_o(cfg), .acy_req_o(ar), .acy_write_o(aw),
		.acy_addr_o(aa), .acy_wdata_o(ad), .acy_ack_i(ack));
	dpdi_top dpdi_top_inst (.sys_clk_i(clk), .sys_rst_i(rst), .conn_open_i(conn),
		.conn_out_inst_i(inst[15:8]), .conn_in_inst_i(inst[7:0]),
		.out_asm_valid_i(ov), .out_asm_data_i(od), .in_asm_data_o(ia), .cfg_wr_i(cwr),
		.cfg_inst_i(cfg[47:40]), .cfg_par_i(cfg[39:32]), .cfg_val_i(cfg[31:0]),
		.acy_req_i(ar), .acy_write_i(aw), .acy_class_i(aa[23:16]), .acy_inst_i(aa[15:8]),
		.acy_attr_i(aa[7:0]), .acy_wdata_i(ad), .acy_ack_o(ack), .acy_err_o(aerr),
		.acy_rdata_o(ard), .target_reached_i(fb[0]), .motor_power_i(fb[1]),
		.running_i(fb[2]), .error_i(fb[3]), .act_speed_i(spd), .act_pos_i(pos),
		.jog_up_o(jup), .jog_down_o(jdn), .release_o(rel), .direct_o(dir),
		.pos_start_o(pst), .target_pos_o(tpos), .err_ack_o(eack), .ref_set_o(rset),
		.ref_val_o(rval), .scale_num_o(snum), .scale_den_o(sden));

	// ****************************************************************
	// Compare, verdict and request helpers
	// ****************************************************************
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tally_and_finish;
		if (mismatches == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish

	// Note the expected answer, then let the scanner issue the request
	task automatic acy(input logic w, input logic [15:0] ci, input logic [7:0] at,
		input logic [31:0] d, input logic [33:0] x);
		acy_q.push_back(x);
		dpdi_scanner_model_inst.acy(w, {ci, at}, d);
	endtask : acy

	// Watcher: every answer pulse consumes the oldest note; read data only where known
	always @(negedge clk) begin
		if (ack) begin
			e = acy_q.pop_front();
			chk({aerr, e[33] ? ard : 32'h0}, {e[32], e[33] ? e[31:0] : 32'h0});
		end
		if (pst) chk(tpos, pos_q.pop_front());
		if (rset) chk(rval, ref_q.pop_front());
		if (eack) acks++;
	end

	// Hang guard, far beyond the fewer than a hundred cycles the sequence needs
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		tally_and_finish();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		void'($urandom(32'h41b9));
		r = $urandom() | 32'h0000_0100;
		t = $urandom();
		repeat (2) @(negedge clk);
		rst = 1'b0;
		chk({snum, sden, tpos}, {32'h0000_0001, 32'h0000_0001, 32'h0});
		// Enabled value taken, disabled value and foreign instance ignored
		dpdi_scanner_model_inst.cfg({8'h68, 8'h1B, 32'h0000_0001});
		dpdi_scanner_model_inst.cfg({8'h68, 8'h1C, r});
		dpdi_scanner_model_inst.cfg({8'h68, 8'h1D, 32'h0000_0000});
		dpdi_scanner_model_inst.cfg({8'h68, 8'h1E, r});
		dpdi_scanner_model_inst.cfg({8'h67, 8'h1D, 32'h0000_0001});
		dpdi_scanner_model_inst.cfg({8'h67, 8'h1E, r});
		@(negedge clk);
		chk({snum, sden}, {r, 32'h0000_0001});
		// Attribute access while running, then at standstill
		fb = 4'h4;
		acy(1'b0, 16'h6401, 8'h1C, 32'h0, {2'b10, r});
		acy(1'b0, 16'h6501, 8'h1C, 32'h0, {2'b01, 32'h0});
		acy(1'b0, 16'h6402, 8'h1C, 32'h0, {2'b01, 32'h0});
		acy(1'b1, 16'h6401, 8'h0A, t, {2'b01, 32'h0});
		fb = 4'h0;
		ref_q.push_back(t);
		acy(1'b1, 16'h6401, 8'h0A, t, {2'b00, 32'h0});
		acy(1'b1, 16'h6401, 8'h1C, t, {2'b00, 32'h0});
		// Cyclic: start on toggle change, none on repeat
		conn = 1'b1;
		pos_q.push_back(t);
		dpdi_scanner_model_inst.frame(16'h2014, t, 48'h0);
		repeat (3) @(negedge clk);
		chk({rel, ia[2]}, 2'b11);
		dpdi_scanner_model_inst.frame(16'h2014, ~t, 48'h0);
		repeat (2) @(negedge clk);
		chk(tpos, t);
		// Channel read of the value written by attribute
		dpdi_scanner_model_inst.frame(16'h2010, t, {32'h0, 16'h101C});
		repeat (4) @(negedge clk);
		chk(ia[127:80], {t, 16'h101C});
		// Channel write lands in the store; a write to the status is refused
		dpdi_scanner_model_inst.frame(16'h2010, t, {~t, 16'h201E});
		repeat (4) @(negedge clk);
		chk({ia[95:80], sden}, {16'h201E, ~t});
		dpdi_scanner_model_inst.frame(16'h2010, t, {t, 16'h2008});
		repeat (4) @(negedge clk);
		chk(ia[95:80], 16'h7008);
		for (int i = 0; i < 4; i++) begin
			dpdi_scanner_model_inst.frame(jcw[i], t, {32'h0, 16'h101C});
			repeat (2) @(negedge clk);
			chk({jup, jdn, dir, rel}, jex[i]);
		end
		dpdi_scanner_model_inst.frame(16'h6010, t, {32'h0, 16'h101C});
		dpdi_scanner_model_inst.frame(16'h6010, t, {32'h0, 16'h101C});
		repeat (2) @(negedge clk);
		chk(acks, 1);
		fb = 4'($urandom());
		spd = 16'($urandom());
		pos = $urandom();
		repeat (2) @(negedge clk);
		chk({ia[9], ia[6], ia[4], ia[0], ia[63:16]}, {fb, pos, spd});
		conn = 1'b0;
		repeat (2) @(negedge clk);
		chk({rel, jup}, 2'b00);
		// Connection open but wrong input instance: cyclic data stays out
		conn = 1'b1;
		inst = 16'h6466;
		dpdi_scanner_model_inst.frame(16'h2011, t, {32'h0, 16'h101C});
		repeat (2) @(negedge clk);
		chk({rel, jup}, 2'b00);
		chk(pos_q.size() + ref_q.size() + acy_q.size(), 0);
		tally_and_finish();
	end
endmodule : tb_top

`default_nettype wire
